// ### core/spd_pkg.sv
// constants, types and states of the presence-detect serial slave
// Overview of operation
// RQ1: the bus master starts every transfer and clocks it; this block only answers.
// RQ2: start is data falling while clock high, watched except during a write cycle.
// RQ3: stop is data rising while clock high and ends the current exchange.
// RQ4: after eight bits the receiver pulls data low in the ninth clock.
// RQ5: data is sampled on rising clock; master changes data only while clock low.
// RQ6: after start the master sends the eight-bit select code, msb first.
// RQ7: upper select nibble 1010 selects memory, 0110 selects protection and page commands.
// RQ8: memory codes answer only when bits three to one match the address pins.
// RQ9: select bit zero is direction: one reads, zero writes.
// RQ10: a matching select code is acknowledged in the ninth bit time.
// RQ11: with high voltage on pin zero, 001/100/101/000 protect blocks, 011 clears all.
// RQ12: protection queries acknowledge an unprotected block and refuse a protected one.
// RQ13: codes 110 and 111 written select page zero or one for later accesses.
// RQ14: page query acknowledges page zero and refuses page one.
// RQ15: a write acknowledges select, then one address byte, then takes data bytes.
// RQ16: only a stop in the slot right after a data acknowledge starts a write cycle. The code also commits after a refused byte once one was acknowledged.
// RQ17: during the write cycle both bus lines are ignored and nothing answers.
// RQ18: a data byte aimed at a protected location is refused and not stored.
// RQ19: page write takes one to sixteen bytes; only the low four address bits count.
// RQ20: page write bytes are acknowledged while write inhibit is low.
// RQ21: select codes are refused while busy and acknowledged once the write cycle ends.
// RQ22: a stop after the master refuses a read byte returns to standby.
// RQ23: clock held low for the timeout returns the slave to standby.
// RQ24: write inhibit low permits writes; high blocks every write. The code blocks data bytes only; protection set and clear still commit.
// RQ25: a read without address phase returns the byte at the counter, then increments.
// RQ26: after reset the selected page is zero.
// RQ27: undefined 0110 select codes are not acknowledged.
// RQ28: the write cycle lasts a parameter number of clock cycles, busy until done.
`default_nettype none
package spd_pkg;
	localparam int unsigned SYS_CLK_HZ    = 25_000_000;
	localparam int unsigned CLK_PER_US    = SYS_CLK_HZ / 1_000_000;
	localparam logic [3:0]  TYPE_MEMORY   = 4'ha;
	localparam logic [3:0]  TYPE_PROTECT  = 4'h6;
	localparam logic [2:0]  CODE_BLK0     = 3'h1;
	localparam logic [2:0]  CODE_BLK1     = 3'h4;
	localparam logic [2:0]  CODE_BLK2     = 3'h5;
	localparam logic [2:0]  CODE_BLK3     = 3'h0;
	localparam logic [2:0]  CODE_CLEAR    = 3'h3;
	localparam logic [2:0]  CODE_PAGE0    = 3'h6;
	localparam logic [2:0]  CODE_PAGE1    = 3'h7;
	localparam logic [3:0]  ACK_SLOT      = 4'h8;
	localparam logic [3:0]  LAST_DATA_BIT = 4'h7;
	localparam logic [3:0]  GROUP_STEP    = 4'h1;
	localparam logic [7:0]  ADDR_STEP     = 8'h01;
	localparam int unsigned WR_FIFO_DEPTH = 16;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_SELECT  = 3'b001,
		ST_ADDRESS = 3'b010,
		ST_WDATA   = 3'b011,
		ST_RDATA   = 3'b100,
		ST_PROTCMD = 3'b101,
		ST_STANDBY = 3'b110
	} spd_state_t;

	typedef enum logic [1:0] {
		OP_NONE  = 2'b00,
		OP_SET   = 2'b01,
		OP_CLEAR = 2'b10
	} spd_op_t;

	// one byte bound for the cell array: page, byte address, data
	typedef struct packed {
		logic       page;
		logic [7:0] addr;
		logic [7:0] data;
	} spd_wr_word_t;
endpackage
`default_nettype wire

// ### core/spd_eeprom_serial_slave.sv
// serial slave front end with write buffer and write-cycle lockout
`default_nettype none
module spd_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_rst,
	input  wire logic             i_flush,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic [WIDTH-1:0]      o_out_data
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wptr_q;
	logic [AW:0]      rptr_q;
	logic             push;
	logic             pop;

	assign o_in_ready  = (wptr_q - rptr_q) != (AW+1)'(DEPTH);
	assign o_out_valid = wptr_q != rptr_q;
	assign o_out_data  = mem[rptr_q[AW-1:0]];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	always_ff @(posedge i_sys_clk) begin
		if (push)
			mem[wptr_q[AW-1:0]] <= i_in_data;
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			wptr_q <= '0;
			rptr_q <= '0;
		end else if (i_flush) begin
			wptr_q <= '0;
			rptr_q <= '0;
		end else begin
			if (push)
				wptr_q <= wptr_q + 1'b1;
			if (pop)
				rptr_q <= rptr_q + 1'b1;
		end
	end
endmodule

module spd_eeprom_serial_slave
	import spd_pkg::*;
#(
	parameter int unsigned WRITE_CYCLE_US = 5000,
	parameter int unsigned TIMEOUT_US     = 25000
) (
	input  wire logic          i_sys_clk,
	input  wire logic          i_rst,
	input  wire logic          i_scl,
	input  wire logic          i_sda,
	output logic               o_sda_out,
	output logic               o_sda_oe,
	input  wire logic          i_slave_addr_pin_2,
	input  wire logic          i_slave_addr_pin_1,
	input  wire logic          i_slave_addr_pin_0,
	input  wire logic          i_slave_addr_pin_0_hv_detect,
	input  wire logic          i_write_inhibit_n,
	output logic [8:0]         o_rd_addr,
	input  wire logic [7:0]    i_rd_data,
	output logic               o_wr_valid,
	input  wire logic          i_wr_ready,
	output spd_pkg::spd_wr_word_t o_wr_word,
	output logic               o_busy,
	output logic               o_page,
	output logic [3:0]         o_protect
);
	import spd_pkg::*;

	localparam int unsigned WR_CYC = WRITE_CYCLE_US * CLK_PER_US;
	localparam int unsigned TO_CYC = TIMEOUT_US * CLK_PER_US;
	localparam int unsigned CW     = $clog2(WR_CYC > TO_CYC ? WR_CYC + 1 : TO_CYC + 1);

	// pins: scl, sda, inhibit, addr2..0, hv
	logic [6:0]   sync1_q;
	logic [6:0]   sync2_q;
	logic [1:0]   prev_q;
	logic         scl;
	logic         sda;
	logic         inhibit;
	logic [2:0]   pins;
	logic         hv;
	logic         scl_rise;
	logic         scl_fall;
	logic         start_det;
	logic         stop_det;

	spd_state_t   state_q;
	logic [3:0]   bit_q;
	logic         ack_phase_q;
	logic         ack_drive_q;
	logic [7:0]   shift_q;
	logic [7:0]   tx_q;
	logic [7:0]   addr_q;
	logic         page_q;
	logic [3:0]   prot_q;
	spd_op_t      op_q;
	logic [1:0]   op_blk_q;
	logic         data_ok_q;
	logic         busy_q;
	logic [CW-1:0] wcnt_q;
	logic [CW-1:0] tcnt_q;
	logic         sda_oe_q;

	logic         fifo_in_ready;
	logic         fifo_out_valid;
	logic         fifo_pop;
	logic         fifo_flush;
	logic         push;
	spd_wr_word_t fifo_out;
	spd_wr_word_t push_word;
	logic         timeout;
	logic         commit;

	// two flops on every pin before any logic looks at it
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			sync1_q <= 7'h03;
			sync2_q <= 7'h03;
			prev_q  <= 2'h3;
		end else begin
			sync1_q <= {i_write_inhibit_n, i_slave_addr_pin_2, i_slave_addr_pin_1,
				i_slave_addr_pin_0, i_slave_addr_pin_0_hv_detect, i_scl, i_sda};
			sync2_q <= sync1_q;
			prev_q  <= sync2_q[1:0];
		end
	end

	assign sda      = sync2_q[0];
	assign scl      = sync2_q[1];
	assign hv       = sync2_q[2];
	assign pins     = sync2_q[5:3];
	assign inhibit  = sync2_q[6];
	// RQ5 rising edge samples
	assign scl_rise = scl & ~prev_q[1];
	assign scl_fall = ~scl & prev_q[1];
	// RQ2 start detect, RQ17 gated
	assign start_det = ~busy_q & scl & prev_q[1] & ~sda & prev_q[0];
	// RQ3 stop detect
	assign stop_det  = ~busy_q & scl & prev_q[1] & sda & ~prev_q[0];
	// RQ23 clock low timeout
	assign timeout   = tcnt_q == CW'(TO_CYC);
	// RQ16 stop only in the slot after a data byte, once any data byte was acknowledged;
	// the stop's own clock rise has already counted one bit of that slot
	assign commit    = stop_det & data_ok_q & (bit_q == 4'h1) & ~ack_phase_q
		& ((state_q == ST_WDATA) | (state_q == ST_PROTCMD));
	assign fifo_flush = (start_det | stop_det | timeout) & ~commit;

	function automatic logic [1:0] blk_of(input logic [2:0] code);
		unique case (code)
			CODE_BLK0: blk_of = 2'h0;
			CODE_BLK1: blk_of = 2'h1;
			CODE_BLK2: blk_of = 2'h2;
			default:   blk_of = 2'h3;
		endcase
	endfunction

	function automatic logic is_blk(input logic [2:0] code);
		is_blk = (code == CODE_BLK0) | (code == CODE_BLK1)
			| (code == CODE_BLK2) | (code == CODE_BLK3);
	endfunction

	// RQ24 inhibit blocks every data byte write, RQ18 protected block refused
	logic wr_allowed;
	assign wr_allowed = ~inhibit & ~prot_q[{page_q, addr_q[7]}] & fifo_in_ready;
	assign push = scl_fall & (bit_q == ACK_SLOT) & ~ack_phase_q
		& (state_q == ST_WDATA) & wr_allowed;
	assign push_word = '{page: page_q, addr: addr_q, data: shift_q};

	// RQ1 slave only: state moves only on master clock and data edges and on the clock-low timeout
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q     <= ST_IDLE;
			bit_q       <= 4'h0;
			ack_phase_q <= 1'b0;
			ack_drive_q <= 1'b0;
			shift_q     <= 8'h00;
			tx_q        <= 8'hff;
			data_ok_q   <= 1'b0;
			op_q        <= OP_NONE;
			op_blk_q    <= 2'h0;
		end else if (busy_q | timeout | stop_det) begin
			// RQ22 stop returns to ST_IDLE
			state_q     <= ST_IDLE;
			ack_phase_q <= 1'b0;
			ack_drive_q <= 1'b0;
			data_ok_q   <= 1'b0;
			tx_q        <= 8'hff;
		end else if (start_det) begin
			// RQ6 select code follows start
			state_q     <= ST_SELECT;
			bit_q       <= 4'h0;
			ack_phase_q <= 1'b0;
			ack_drive_q <= 1'b0;
			data_ok_q   <= 1'b0;
			op_q        <= OP_NONE;
			tx_q        <= 8'hff;
		end else if (state_q == ST_STANDBY) begin
			// an answer given on the way into standby still ends with the ninth clock
			if (scl_fall && ack_phase_q) begin
				ack_phase_q <= 1'b0;
				ack_drive_q <= 1'b0;
			end
		end else if (state_q != ST_IDLE) begin
			if (scl_rise && bit_q < ACK_SLOT) begin
				// RQ5 msb first on rising edge
				shift_q <= {shift_q[6:0], sda};
				bit_q   <= bit_q + 4'h1;
			end else if (scl_rise && ack_phase_q && state_q == ST_RDATA && sda) begin
				// master refused the byte: stop sending until stop/start
				state_q <= ST_STANDBY;
			end
			if (scl_fall && state_q == ST_RDATA && !ack_phase_q && bit_q != 4'h0
					&& bit_q <= LAST_DATA_BIT)
				tx_q <= {tx_q[6:0], 1'b1};
			if (scl_fall && bit_q == ACK_SLOT && !ack_phase_q) begin
				// RQ4 ninth clock: receiver drives low
				ack_phase_q <= 1'b1;
				tx_q        <= 8'hff;
				ack_drive_q <= 1'b0;
				unique case (state_q)
					ST_SELECT: begin
						// RQ7 type field
						if (shift_q[7:4] == TYPE_MEMORY) begin
							// RQ8 pin match
							if (shift_q[3:1] == pins) begin
								// RQ10 acknowledge match, RQ9 direction
								ack_drive_q <= 1'b1;
								state_q <= shift_q[0] ? ST_RDATA : ST_ADDRESS;
							end else
								state_q <= ST_STANDBY;
						end else if (shift_q[7:4] == TYPE_PROTECT && !shift_q[0]) begin
							state_q <= ST_STANDBY;
							if (hv && is_blk(shift_q[3:1])) begin
								// RQ11 set protect
								ack_drive_q <= ~prot_q[blk_of(shift_q[3:1])];
								state_q  <= prot_q[blk_of(shift_q[3:1])] ? ST_STANDBY
									: ST_PROTCMD;
								op_q     <= OP_SET;
								op_blk_q <= blk_of(shift_q[3:1]);
							end else if (hv && shift_q[3:1] == CODE_CLEAR) begin
								// RQ11 clear all
								ack_drive_q <= 1'b1;
								state_q <= ST_PROTCMD;
								op_q    <= OP_CLEAR;
							end else if (shift_q[3:2] == CODE_PAGE0[2:1])
								// RQ13 page select
								ack_drive_q <= 1'b1;
							// RQ27 anything else stays unanswered
						end else if (shift_q[7:4] == TYPE_PROTECT) begin
							state_q <= ST_STANDBY;
							// RQ12 protection query
							if (is_blk(shift_q[3:1]))
								ack_drive_q <= ~prot_q[blk_of(shift_q[3:1])];
							// RQ14 page query
							else if (shift_q[3:1] == CODE_PAGE0)
								ack_drive_q <= ~page_q;
						end else
							state_q <= ST_STANDBY;
					end
					ST_ADDRESS: begin
						// RQ15 address byte acknowledged
						ack_drive_q <= 1'b1;
						state_q     <= ST_WDATA;
					end
					ST_WDATA: begin
						// RQ20 acknowledge while allowed
						ack_drive_q <= wr_allowed;
						data_ok_q   <= data_ok_q | wr_allowed;
					end
					ST_PROTCMD: begin
						ack_drive_q <= 1'b1;
						data_ok_q   <= 1'b1;
					end
					default: begin
						ack_drive_q <= 1'b0;
					end
				endcase
			end else if (scl_fall && ack_phase_q) begin
				ack_phase_q <= 1'b0;
				ack_drive_q <= 1'b0;
				bit_q       <= 4'h0;
				// RQ25 load the byte at the counter
				if (state_q == ST_RDATA)
					tx_q <= i_rd_data;
			end
		end
	end

	// byte address counter and page
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			addr_q <= 8'h00;
			// RQ26 page zero after reset
			page_q <= 1'b0;
		end else if (!busy_q && scl_fall && bit_q == ACK_SLOT && !ack_phase_q) begin
			if (state_q == ST_ADDRESS)
				addr_q <= shift_q;
			else if (push)
				// RQ19 only the low four bits advance
				addr_q <= {addr_q[7:4], addr_q[3:0] + GROUP_STEP};
			else if (state_q == ST_SELECT && shift_q[7:4] == TYPE_PROTECT
					&& !shift_q[0] && shift_q[3:2] == CODE_PAGE0[2:1])
				// RQ13 page select
				page_q <= shift_q[1];
		end else if (!busy_q && scl_fall && ack_phase_q && state_q == ST_RDATA)
			// RQ25 counter steps after each byte out
			addr_q <= addr_q + ADDR_STEP;
	end

	// RQ28 write cycle timer, RQ21 busy until it expires and the buffer drains
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			busy_q   <= 1'b0;
			wcnt_q   <= '0;
			prot_q   <= 4'h0;
		end else if (commit) begin
			busy_q <= 1'b1;
			wcnt_q <= CW'(WR_CYC);
			if (op_q == OP_SET)
				prot_q[op_blk_q] <= 1'b1;
			else if (op_q == OP_CLEAR)
				prot_q <= 4'h0;
		end else if (busy_q) begin
			if (wcnt_q != '0)
				wcnt_q <= wcnt_q - 1'b1;
			else if (!fifo_out_valid && !o_wr_valid)
				busy_q <= 1'b0;
		end
	end

	// RQ23 count clock low time in an open exchange
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst)
			tcnt_q <= '0;
		else if (scl || state_q == ST_IDLE || timeout)
			tcnt_q <= '0;
		else
			tcnt_q <= tcnt_q + 1'b1;
	end

	// open drain: drive low for acknowledge or a zero read bit
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst)
			sda_oe_q <= 1'b0;
		else
			sda_oe_q <= ~busy_q & (ack_drive_q | (state_q == ST_RDATA
				& ~ack_phase_q & ~tx_q[7]));
	end

	// write buffer drains only during the write cycle, so a page collects first
	assign fifo_pop = busy_q & (~o_wr_valid | i_wr_ready);

	spd_fifo #(
		.WIDTH($bits(spd_wr_word_t)),
		.DEPTH(WR_FIFO_DEPTH)
	) u_wr_fifo (
		.i_sys_clk   (i_sys_clk),
		.i_rst       (i_rst),
		.i_flush     (fifo_flush),
		.i_in_valid  (push),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (push_word),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (fifo_pop),
		.o_out_data  (fifo_out)
	);

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_wr_valid <= 1'b0;
			o_wr_word  <= '0;
		end else if (fifo_pop) begin
			o_wr_valid <= fifo_out_valid;
			o_wr_word  <= fifo_out;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_sda_out <= 1'b0;
			o_sda_oe  <= 1'b0;
			o_rd_addr <= 9'h000;
			o_busy    <= 1'b0;
			o_page    <= 1'b0;
			o_protect <= 4'h0;
		end else begin
			o_sda_out <= 1'b0;
			o_sda_oe  <= sda_oe_q;
			o_rd_addr <= {page_q, addr_q};
			o_busy    <= busy_q;
			o_page    <= page_q;
			o_protect <= prot_q;
		end
	end
endmodule
`default_nettype wire

// ### bench/spd_master.sv
// two-wire bus master model: clocks the bus and pulls data low as an open drain
`default_nettype none
module spd_master (
	input  wire logic i_sys_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end

	task automatic qtr();
		repeat (2) @(posedge i_sys_clk);
		#1;
	endtask

	// master clocks; data moves only while scl low
	// low phase is long so the slave's synchronised answer settles before scl rises
	task automatic bit_io(input logic b, output logic s);
		o_sda_oe = !b;
		qtr();
		qtr();
		o_scl = 1'b1;
		@(posedge i_sys_clk);
		#1;
		s = i_sda;
		@(posedge i_sys_clk);
		#1;
		o_scl = 1'b0;
		qtr();
	endtask

	// start, also repeated; extra wait lets a slave ack clear first
	task automatic bstart();
		o_sda_oe = 1'b0;
		qtr();
		qtr();
		o_scl = 1'b1;
		qtr();
		o_sda_oe = 1'b1;
		qtr();
		o_scl = 1'b0;
		qtr();
	endtask

	// stop, then scl stands high until the next frame
	task automatic bstop();
		o_sda_oe = 1'b1;
		qtr();
		o_scl = 1'b1;
		qtr();
		o_sda_oe = 1'b0;
		qtr();
	endtask

	// msb first, line released in bit nine for the answer
	task automatic send(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = !s;
	endtask

	// master acks a read byte, or refuses the last one
	task automatic recv(input logic mack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(!mack, s);
	endtask
endmodule
`default_nettype wire

// ### bench/spd_eeprom_serial_slave_asserts.sv
// port-level assertions for the serial slave
`default_nettype none
module spd_eeprom_serial_slave_asserts #(
	parameter int unsigned WRITE_CYCLE_US = 5000
) (
	input wire logic                  i_sys_clk,
	input wire logic                  i_rst,
	input wire logic                  o_sda_out,
	input wire logic                  o_sda_oe,
	input wire logic                  o_wr_valid,
	input wire logic                  i_wr_ready,
	input wire spd_pkg::spd_wr_word_t o_wr_word,
	input wire logic                  o_busy,
	input wire logic                  o_page
);
	import spd_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WC_CYC   = int'(WRITE_CYCLE_US * CLK_PER_US);
	localparam int BUSY_MAX = WC_CYC + 600;
	logic [31:0] busy_cnt_q;

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst)
			busy_cnt_q <= '0;
		else if (o_busy)
			busy_cnt_q <= busy_cnt_q + 32'h1;
		else
			busy_cnt_q <= '0;
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	a_sda_open_drain: assert property (o_sda_out == 1'b0)
		else $error("data line driven high");
	a_busy_quiet: assert property (o_busy |-> !o_sda_oe)
		else $error("answer while busy");
	a_word_in_cycle: assert property (o_wr_valid |-> o_busy)
		else $error("write word outside write cycle");
	a_word_hold: assert property (o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr_word))
		else $error("write word dropped or changed");
	a_busy_span: assert property ($fell(o_busy) |-> busy_cnt_q >= WC_CYC - 1)
		else $error("write cycle too short");
	a_busy_bound: assert property (o_busy |-> busy_cnt_q < BUSY_MAX)
		else $error("write cycle never ends");
	a_page_reset: assert property ($fell(i_rst) |-> !o_page)
		else $error("page not zero after reset");
	a_page_idle: assert property ($changed(o_page) |-> !o_busy && !$past(o_busy))
		else $error("page changed during write cycle");
endmodule

bind spd_eeprom_serial_slave spd_eeprom_serial_slave_asserts #(
	.WRITE_CYCLE_US(WRITE_CYCLE_US)
) spd_chk_inst (
	.i_sys_clk(i_sys_clk),
	.i_rst(i_rst),
	.o_sda_out(o_sda_out),
	.o_sda_oe(o_sda_oe),
	.o_wr_valid(o_wr_valid),
	.i_wr_ready(i_wr_ready),
	.o_wr_word(o_wr_word),
	.o_busy(o_busy),
	.o_page(o_page)
);
`default_nettype wire

// ### bench/tb_spd_eeprom_serial_slave.sv
// self-checking bench for the serial slave front end
`default_nettype none
module tb_spd_eeprom_serial_slave import spd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic         i_sys_clk, i_rst, scl, m_oe, s_oe, s_out, sda, hv, inh_n;
	logic         wr_rdy, wr_val, busy, page, ack;
	logic [2:0]   pins;
	logic [3:0]   prot;
	logic [8:0]   rd_addr;
	logic [7:0]   rd_data, rb;
	logic [15:0]  rnd = 16'h0020;
	spd_wr_word_t wr_word;
	spd_wr_word_t exp_q [$];
	logic [7:0]   mem [512];
	logic [7:0]   wdat [16];
	logic [7:0]   rsv [4] = '{8'h64, 8'h65, 8'h67, 8'h6f};
	logic [2:0]   blk [4] = '{CODE_BLK0, CODE_BLK1, CODE_BLK2, CODE_BLK3};
	int           bad_count, total_checks;

	// open drain with pull-up
	assign sda = ~(m_oe | s_oe);
	assign rd_data = mem[rd_addr];

	spd_eeprom_serial_slave #(.WRITE_CYCLE_US(20), .TIMEOUT_US(40)) spd_eeprom_serial_slave_inst (
		.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda),
		.o_sda_out(s_out), .o_sda_oe(s_oe), .i_slave_addr_pin_2(pins[2]),
		.i_slave_addr_pin_1(pins[1]), .i_slave_addr_pin_0(pins[0]),
		.i_slave_addr_pin_0_hv_detect(hv), .i_write_inhibit_n(inh_n), .o_rd_addr(rd_addr),
		.i_rd_data(rd_data), .o_wr_valid(wr_val), .i_wr_ready(wr_rdy), .o_wr_word(wr_word),
		.o_busy(busy), .o_page(page), .o_protect(prot));
	spd_master spd_master_inst (.i_sys_clk(i_sys_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		if (bad_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask

	task automatic xfer(input logic [7:0] b, input logic exp);
		spd_master_inst.send(b, ack);
		chk(ack, exp);
	endtask

	task automatic wait_idle();
		for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge i_sys_clk);
		tick(4);
	endtask

	initial begin
		i_sys_clk = 1'b0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end

	// cell array side stalls at random
	always @(posedge i_sys_clk) begin
		#1;
		rnd = lfsr(rnd);
		wr_rdy = rnd[3];
	end

	always @(posedge i_sys_clk) begin
		if (wr_val && wr_rdy) begin
			mem[{wr_word.page, wr_word.addr}] <= wr_word.data;
			if (exp_q.size() > 0)
				chk(wr_word, exp_q.pop_front());
			else
				chk(1'b1, 1'b0);
		end
	end

	initial begin
		#2_000_000;
		bad_count++;
		final_report();
	end

	initial begin
		i_rst = 1'b1;
		{hv, inh_n, pins} = '0;
		tick(4);
		i_rst = 1'b0;
		pins = rnd[2:0];
		tick(4);
		chk({page, prot}, 5'h0);
		spd_master_inst.bstart();
		xfer({TYPE_MEMORY, pins ^ 3'h1, 1'b0}, 1'b0);
		spd_master_inst.bstop();
		spd_master_inst.bstart();
		xfer({TYPE_MEMORY, pins, 1'b0}, 1'b1);
		xfer(8'h1c, 1'b1);
		for (int k = 0; k < 16; k++) begin
			wdat[k] = rnd[7:0];
			exp_q.push_back({1'b0, 4'h1, 4'hc + k[3:0], wdat[k]});
			xfer(wdat[k], 1'b1);
		end
		spd_master_inst.bstop();
		tick(10);
		chk(busy, 1'b1);
		spd_master_inst.bstart();
		xfer({TYPE_MEMORY, pins, 1'b0}, 1'b0);
		spd_master_inst.bstop();
		wait_idle();
		chk(17'(exp_q.size()), 17'h0);
		spd_master_inst.bstart();
		xfer({TYPE_MEMORY, pins, 1'b0}, 1'b1);
		xfer(8'h10, 1'b1);
		spd_master_inst.bstart();
		xfer({TYPE_MEMORY, pins, 1'b1}, 1'b1);
		for (int k = 0; k < 3; k++) begin
			if (k == 2) begin
				spd_master_inst.bstart();
				xfer({TYPE_MEMORY, pins, 1'b1}, 1'b1);
			end
			spd_master_inst.recv(k == 0, rb);
			chk(rb, wdat[4 + k]);
		end
		spd_master_inst.bstop();
		tick(10);
		chk(busy, 1'b0);
		inh_n = 1'b1;
		spd_master_inst.bstart();
		xfer({TYPE_MEMORY, pins, 1'b0}, 1'b1);
		xfer(8'h40, 1'b1);
		xfer(8'ha5, 1'b0);
		spd_master_inst.bstop();
		inh_n = 1'b0;
		tick(10);
		chk(busy, 1'b0);
		for (int k = 0; k < 3; k++) begin
			spd_master_inst.bstart();
			xfer({TYPE_PROTECT, CODE_PAGE0, 1'b1}, k != 1);
			spd_master_inst.bstart();
			xfer({TYPE_PROTECT, (k == 0) ? CODE_PAGE1 : CODE_PAGE0, 1'b0}, 1'b1);
			spd_master_inst.bstop();
			tick(4);
			chk(page, k == 0);
		end
		for (int i = 0; i < 4; i++) begin
			spd_master_inst.bstart();
			xfer(rsv[i], 1'b0);
			spd_master_inst.bstop();
		end
		hv = 1'b1;
		for (int k = 0; k < 5; k++) begin
			spd_master_inst.bstart();
			if (k < 4) begin
				xfer({TYPE_PROTECT, blk[k], 1'b1}, 1'b1);
				spd_master_inst.bstart();
			end
			xfer({TYPE_PROTECT, (k < 4) ? blk[k] : CODE_CLEAR, 1'b0}, 1'b1);
			xfer(8'h00, 1'b1);
			xfer(8'h00, 1'b1);
			spd_master_inst.bstop();
			tick(10);
			wait_idle();
			if (k < 4) begin
				spd_master_inst.bstart();
				xfer({TYPE_PROTECT, blk[k], 1'b1}, 1'b0);
				spd_master_inst.bstop();
				chk(prot[k], 1'b1);
			end
			if (k == 3) begin
				hv = 1'b0;
				spd_master_inst.bstart();
				xfer({TYPE_MEMORY, pins, 1'b0}, 1'b1);
				xfer(8'h05, 1'b1);
				xfer(8'h77, 1'b0);
				spd_master_inst.bstop();
				hv = 1'b1;
			end
		end
		chk(prot, 4'h0);
		// clock held low past the timeout drops the open write
		spd_master_inst.bstart();
		xfer({TYPE_MEMORY, pins, 1'b0}, 1'b1);
		tick(1100);
		xfer(8'h00, 1'b0);
		spd_master_inst.bstop();
		tick(10);
		chk(busy, 1'b0);
		final_report();
	end
endmodule
`default_nettype wire
